// ===== logic/dspc_cfg.svh
// Constants for the operand and arithmetic datapath: fields, offsets, flag positions
`ifndef DSPC_CFG_SVH
`define DSPC_CFG_SVH

// Instruction word fields
`define DSPC_F_CLASS    23:19
`define DSPC_F_DMODE    18:16
`define DSPC_F_WB       15:12
`define DSPC_F_WS       11:8
`define DSPC_F_WD       7:4
`define DSPC_F_SMODE    3:1
`define DSPC_F_LIT5     4:0
`define DSPC_F_LIT10    13:4
`define DSPC_F_WN       3:0
`define DSPC_F_FADDR    12:0
`define DSPC_F_TOW0     13
`define DSPC_F_ACCSEL   0
`define DSPC_F_SLIT4    7:4
`define DSPC_F_MPAIR    15:12
`define DSPC_F_XCODE    11:8
`define DSPC_F_YCODE    7:4
`define DSPC_F_XDST     3:2
`define DSPC_F_YDST     1:0
`define DSPC_F_AWB      18:17
`define DSPC_F_MACACC   16

// Word step of indirect pointer updates
`define DSPC_PTR_STEP   16'h0002
`define DSPC_IMPLICIT_W 4'h0
`define DSPC_AWB_REG    4'hd
`define DSPC_INDEX_REG  4'hc

// Status vector bit positions
`define DSPC_ST_C       0
`define DSPC_ST_Z       1
`define DSPC_ST_OV      2
`define DSPC_ST_N       3
`define DSPC_ST_DC      4
`define DSPC_ST_SA      5
`define DSPC_ST_SB      6
`define DSPC_ST_OA      7
`define DSPC_ST_OB      8
`define DSPC_ST_RESET   9'h000

// Register word indices on the bus (byte address = index * 4)
`define DSPC_IDX_W0     5'h00
`define DSPC_IDX_STATUS 5'h10
`define DSPC_IDX_ACCALO 5'h11
`define DSPC_IDX_ACCAHI 5'h12
`define DSPC_IDX_ACCBLO 5'h13
`define DSPC_IDX_ACCBHI 5'h14
`define DSPC_RESP_OKAY  2'h0
`define DSPC_RESP_SLV   2'h2

`endif

// ===== logic/dspc_pkg.sv
// Types for the operand and arithmetic datapath
package dspc_pkg;

    typedef enum logic [4:0] {
        DSPC_NOP       = 5'h00,
        DSPC_ADD_F     = 5'h01,
        DSPC_ADD_WITH_CARRY_OP_F    = 5'h02,
        DSPC_ADD_L10   = 5'h03,
        DSPC_ADD_WITH_CARRY_OP_L10  = 5'h04,
        DSPC_ADD_WWW   = 5'h05,
        DSPC_ADD_WITH_CARRY_OP_WWW  = 5'h06,
        DSPC_ADD_WL5   = 5'h07,
        DSPC_ADD_WITH_CARRY_OP_WL5  = 5'h08,
        DSPC_ADD_WACC  = 5'h09,
        DSPC_ADD_AB    = 5'h0a,
        DSPC_ASR_F     = 5'h0b,
        DSPC_ASR_WW    = 5'h0c,
        DSPC_ASR_IMPLICIT_FILE_OP_REGISTER  = 5'h0d,
        DSPC_ASR_WL5   = 5'h0e,
        DSPC_MAC       = 5'h10
    } dspc_op_t;

    typedef enum logic [2:0] {
        DSPC_AM_DIRECT  = 3'h0,
        DSPC_AM_IND     = 3'h1,
        DSPC_AM_POSTINC = 3'h2,
        DSPC_AM_POSTDEC = 3'h3,
        DSPC_AM_PREINC  = 3'h4,
        DSPC_AM_PREDEC  = 3'h5,
        DSPC_AM_INDEXED = 3'h6
    } dspc_am_t;

    typedef enum logic [1:0] {
        DSPC_K_NONE = 2'h0,
        DSPC_K_ADD  = 2'h1,
        DSPC_K_ASR1 = 2'h2,
        DSPC_K_ASRN = 2'h3
    } dspc_alu_t;

endpackage

// ===== logic/dspc_core.sv
// Operand selection, integer add/shift and DSP operand datapath with AXI4-Lite access
//
// Contract
// - Sixteen working registers, each selectable by a 4-bit field as base, source or dest.
// - File register forms use W0 as implicit second operand and alternative destination.
// - Add and add-with-carry sum operands (plus carry) and set C, DC, N, OV, Z in one cycle.
// - Add-with-carry immediate adds a 10-bit literal and carry into Wn and writes Wn.
// - Accumulator add is a 40-bit signed add into an accumulator touching only OA/OB/SA/SB.
// - One-bit arithmetic right shift keeps the sign and sets C, N, OV, Z.
// - Multi-bit arithmetic right shift by register or 5-bit literal writes Wnd, sets N and Z.
// - Multiply operands are one of six distinct pairs from W4 to W7.
// - Square operands use one register from W4 to W7 for both inputs.
// - X prefetch uses W8 or W9, post-modify +-2/4/6, none, W9+W12 indexed, or omitted.
// - Y prefetch uses W10 or W11 with the same steps, W11+W12 indexed, or omitted.
// - Prefetched X and Y data land only in W4 to W7.
// - Operands use direct, indirect, pre/post inc/dec; accumulator source adds reg offset.
// - An instruction is a 24-bit word whose top 5 bits are the opcode.
// - Accumulator write-back goes only to W13 or to [W13] with post-increment by two.
`timescale 1ns/1ps
`include "dspc_cfg.svh"

module dspc_core
    import dspc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        instrValid,
    input  wire logic [23:0] instrWord,
    output logic             memRe,
    output logic [15:0]      memRAddr,
    input  wire logic [15:0] memRData,
    output logic             memWe,
    output logic [15:0]      memWAddr,
    output logic [15:0]      memWData,
    output logic             xRe,
    output logic [15:0]      xAddr,
    input  wire logic [15:0] xRData,
    output logic             yRe,
    output logic [15:0]      yAddr,
    input  wire logic [15:0] yRData,
    output logic [8:0]       statusFlags
);

    logic [15:0]        wQ [16];
    logic [15:0]        wD [16];
    logic [39:0]        accQ [2];
    logic [39:0]        accD [2];
    logic [8:0]         statusQ;
    logic [8:0]         statusD;
    logic               bvalidQ;
    logic [1:0]         brespQ;
    logic               rvalidQ;
    logic [1:0]         rrespQ;
    logic [31:0]        rdataQ;
    logic               busWr;
    logic [4:0]         busWrIdx;
    logic               busWrMapped;
    logic [4:0]         busRdIdx;
    dspc_op_t           op;
    dspc_am_t           sMode;
    dspc_am_t           dMode;
    dspc_alu_t          aluKind;
    logic [15:0]        aluA;
    logic [15:0]        aluB;
    logic               aluCin;
    logic [4:0]         shAmt;
    logic [15:0]        res;
    logic [16:0]        sum17;
    logic [4:0]         nib5;
    logic               dstFile;
    logic [3:0]         dstReg;
    dspc_am_t           dstMode;
    logic [15:0]        srcVal;
    logic               accEn;
    logic               accSel;
    logic [39:0]        accAddend;
    logic [40:0]        accSum;
    logic [39:0]        srcWide;
    logic [3:0]         slit4;
    logic [4:0]         pairCode;
    logic signed [31:0] prod;
    logic [3:0]         pfCode [2];
    logic [3:0]         pfReg [2];

    // Effective address of an indirect access
    function automatic logic [15:0] effAddr(input dspc_am_t m, input logic [15:0] v,
                                            input logic [15:0] idx);
        unique case (m)
            DSPC_AM_PREINC:  effAddr = v + `DSPC_PTR_STEP;
            DSPC_AM_PREDEC:  effAddr = v - `DSPC_PTR_STEP;
            DSPC_AM_INDEXED: effAddr = v + idx;
            default:         effAddr = v;
        endcase
    endfunction

    // Pointer value left behind by an indirect access
    function automatic logic [15:0] ptrNext(input dspc_am_t m, input logic [15:0] v);
        unique case (m)
            DSPC_AM_POSTINC, DSPC_AM_PREINC: ptrNext = v + `DSPC_PTR_STEP;
            DSPC_AM_POSTDEC, DSPC_AM_PREDEC: ptrNext = v - `DSPC_PTR_STEP;
            default:                         ptrNext = v;
        endcase
    endfunction

    // Multiplier pair: {valid, first W4..W7 offset, second offset}
    function automatic logic [4:0] pairOf(input logic [3:0] c);
        unique case (c)
            4'h0:    pairOf = 5'h11;
            4'h1:    pairOf = 5'h12;
            4'h2:    pairOf = 5'h13;
            4'h3:    pairOf = 5'h16;
            4'h4:    pairOf = 5'h17;
            4'h5:    pairOf = 5'h1b;
            4'h8:    pairOf = 5'h10;
            4'h9:    pairOf = 5'h15;
            4'ha:    pairOf = 5'h1a;
            4'hb:    pairOf = 5'h1f;
            default: pairOf = 5'h00;
        endcase
    endfunction

    // Signed post-modify step of a prefetch pointer
    function automatic logic [15:0] pfStep(input logic [2:0] s);
        unique case (s)
            3'h2:    pfStep = 16'h0002;
            3'h3:    pfStep = 16'h0004;
            3'h4:    pfStep = 16'h0006;
            3'h5:    pfStep = 16'hfffe;
            3'h6:    pfStep = 16'hfffc;
            3'h7:    pfStep = 16'hfffa;
            default: pfStep = 16'h0000;
        endcase
    endfunction

    assign op    = dspc_op_t'(instrWord[`DSPC_F_CLASS]);
    assign sMode = dspc_am_t'(instrWord[`DSPC_F_SMODE]);
    assign dMode = dspc_am_t'(instrWord[`DSPC_F_DMODE]);
    assign slit4 = instrWord[`DSPC_F_SLIT4];

    // Bus writes wait while an instruction executes, so the two never collide
    assign busWr    = awvalid && wvalid && !bvalidQ && !instrValid;
    assign awready  = busWr;
    assign wready   = busWr;
    assign busWrIdx = awaddr[6:2];
    assign busWrMapped = (awaddr[31:7] == 25'h0) && (busWrIdx <= `DSPC_IDX_ACCBHI);
    assign arready  = !rvalidQ;
    assign busRdIdx = araddr[6:2];
    assign bvalid   = bvalidQ;
    assign bresp    = brespQ;
    assign rvalid   = rvalidQ;
    assign rresp    = rrespQ;
    assign rdata    = rdataQ;
    assign statusFlags = statusQ;

    always_comb
    begin
        wD        = wQ;
        accD      = accQ;
        statusD   = statusQ;
        memRe     = 1'b0;
        memRAddr  = 16'h0;
        memWe     = 1'b0;
        memWAddr  = 16'h0;
        memWData  = 16'h0;
        xRe       = 1'b0;
        xAddr     = 16'h0;
        yRe       = 1'b0;
        yAddr     = 16'h0;
        aluKind   = DSPC_K_NONE;
        aluA      = 16'h0;
        aluB      = 16'h0;
        aluCin    = 1'b0;
        shAmt     = 5'h0;
        res       = 16'h0;
        dstFile   = 1'b0;
        dstReg    = 4'h0;
        dstMode   = DSPC_AM_DIRECT;
        accEn     = 1'b0;
        accSel    = instrWord[`DSPC_F_ACCSEL];
        accAddend = 40'h0;
        srcWide   = 40'h0;
        pairCode  = 5'h0;
        prod      = 32'sh0;
        pfCode[0] = instrWord[`DSPC_F_XCODE];
        pfCode[1] = instrWord[`DSPC_F_YCODE];
        pfReg[0]  = {3'b100, pfCode[0][3]};
        pfReg[1]  = {3'b101, pfCode[1][3]};
        // Source operand fetch shared by the Ws forms
        memRAddr  = effAddr(sMode, wQ[instrWord[`DSPC_F_WS]], wQ[instrWord[`DSPC_F_WB]]);
        srcVal    = (sMode == DSPC_AM_DIRECT) ? wQ[instrWord[`DSPC_F_WS]] : memRData;
        if (instrValid)
        begin
            unique case (op)
                DSPC_ADD_F, DSPC_ADD_WITH_CARRY_OP_F, DSPC_ASR_F:
                begin
                    memRe    = 1'b1;
                    memRAddr = {3'b000, instrWord[`DSPC_F_FADDR]};
                    aluA     = memRData;
                    aluB     = wQ[`DSPC_IMPLICIT_W];
                    aluCin   = (op == DSPC_ADD_WITH_CARRY_OP_F) && statusQ[`DSPC_ST_C];
                    aluKind  = (op == DSPC_ASR_F) ? DSPC_K_ASR1 : DSPC_K_ADD;
                    dstFile  = !instrWord[`DSPC_F_TOW0];
                    dstReg   = `DSPC_IMPLICIT_W;
                end
                DSPC_ADD_L10, DSPC_ADD_WITH_CARRY_OP_L10:
                begin
                    aluA    = wQ[instrWord[`DSPC_F_WN]];
                    aluB    = {6'h00, instrWord[`DSPC_F_LIT10]};
                    aluCin  = (op == DSPC_ADD_WITH_CARRY_OP_L10) && statusQ[`DSPC_ST_C];
                    aluKind = DSPC_K_ADD;
                    dstReg  = instrWord[`DSPC_F_WN];
                end
                DSPC_ADD_WWW, DSPC_ADD_WITH_CARRY_OP_WWW, DSPC_ADD_WL5, DSPC_ADD_WITH_CARRY_OP_WL5:
                begin
                    aluA    = wQ[instrWord[`DSPC_F_WB]];
                    aluCin  = ((op == DSPC_ADD_WITH_CARRY_OP_WWW) || (op == DSPC_ADD_WITH_CARRY_OP_WL5))
                              && statusQ[`DSPC_ST_C];
                    aluKind = DSPC_K_ADD;
                    dstMode = dMode;
                    if ((op == DSPC_ADD_WWW) || (op == DSPC_ADD_WITH_CARRY_OP_WWW))
                    begin
                        memRe  = (sMode != DSPC_AM_DIRECT);
                        aluB   = srcVal;
                        dstReg = instrWord[`DSPC_F_WD];
                        wD[instrWord[`DSPC_F_WS]] = ptrNext(sMode, wQ[instrWord[`DSPC_F_WS]]);
                    end
                    else
                    begin
                        aluB   = {11'h000, instrWord[`DSPC_F_LIT5]};
                        dstReg = instrWord[`DSPC_F_WS];
                    end
                end
                DSPC_ASR_WW:
                begin
                    memRe   = (sMode != DSPC_AM_DIRECT);
                    aluA    = srcVal;
                    aluKind = DSPC_K_ASR1;
                    dstReg  = instrWord[`DSPC_F_WD];
                    dstMode = dMode;
                    wD[instrWord[`DSPC_F_WS]] = ptrNext(sMode, wQ[instrWord[`DSPC_F_WS]]);
                end
                DSPC_ASR_IMPLICIT_FILE_OP_REGISTER, DSPC_ASR_WL5:
                begin
                    aluA    = wQ[instrWord[`DSPC_F_WB]];
                    aluKind = DSPC_K_ASRN;
                    shAmt   = (op == DSPC_ASR_WL5) ? instrWord[`DSPC_F_LIT5]
                              : {1'b0, wQ[instrWord[`DSPC_F_WS]][3:0]};
                    dstReg  = (op == DSPC_ASR_WL5) ? instrWord[`DSPC_F_WS]
                              : instrWord[`DSPC_F_WD];
                end
                DSPC_ADD_WACC:
                begin
                    memRe   = (sMode != DSPC_AM_DIRECT);
                    srcWide = {{8{srcVal[15]}}, srcVal, 16'h0000};
                    accAddend = slit4[3] ? (srcWide << (4'h0 - slit4))
                                : 40'($signed(srcWide) >>> slit4);
                    accEn   = 1'b1;
                    wD[instrWord[`DSPC_F_WS]] = ptrNext(sMode, wQ[instrWord[`DSPC_F_WS]]);
                end
                DSPC_ADD_AB:
                begin
                    accAddend = accQ[!accSel];
                    accEn     = 1'b1;
                end
                DSPC_MAC:
                begin
                    accSel   = instrWord[`DSPC_F_MACACC];
                    pairCode = pairOf(instrWord[`DSPC_F_MPAIR]);
                    prod     = $signed(wQ[{2'b01, pairCode[3:2]}])
                             * $signed(wQ[{2'b01, pairCode[1:0]}]);
                    accAddend = {{8{prod[31]}}, prod};
                    accEn    = pairCode[4];
                    // Write-back of the other accumulator
                    unique case (instrWord[`DSPC_F_AWB])
                        2'h1: wD[`DSPC_AWB_REG] = accQ[!accSel][31:16];
                        2'h2:
                        begin
                            memWe    = 1'b1;
                            memWAddr = wQ[`DSPC_AWB_REG];
                            memWData = accQ[!accSel][31:16];
                            wD[`DSPC_AWB_REG] = wQ[`DSPC_AWB_REG] + `DSPC_PTR_STEP;
                        end
                        default: ;
                    endcase
                    xRe   = (pfCode[0] != 4'h0);
                    yRe   = (pfCode[1] != 4'h0);
                    xAddr = (pfCode[0] == 4'h8) ? wQ[pfReg[0]] + wQ[`DSPC_INDEX_REG]
                            : wQ[pfReg[0]];
                    yAddr = (pfCode[1] == 4'h8) ? wQ[pfReg[1]] + wQ[`DSPC_INDEX_REG]
                            : wQ[pfReg[1]];
                    if (xRe)
                    begin
                        wD[pfReg[0]] = wQ[pfReg[0]] + pfStep(pfCode[0][2:0]);
                        wD[{2'b01, instrWord[`DSPC_F_XDST]}] = xRData;
                    end
                    if (yRe)
                    begin
                        wD[pfReg[1]] = wQ[pfReg[1]] + pfStep(pfCode[1][2:0]);
                        wD[{2'b01, instrWord[`DSPC_F_YDST]}] = yRData;
                    end
                end
                default: ;
            endcase
        end

        // Integer result and flags
        sum17 = {1'b0, aluA} + {1'b0, aluB} + {16'h0000, aluCin};
        nib5  = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, aluCin};
        unique case (aluKind)
            DSPC_K_ADD:
            begin
                res = sum17[15:0];
                statusD[`DSPC_ST_C]  = sum17[16];
                statusD[`DSPC_ST_DC] = nib5[4];
                statusD[`DSPC_ST_OV] = (aluA[15] == aluB[15]) && (res[15] != aluA[15]);
            end
            DSPC_K_ASR1:
            begin
                res = {aluA[15], aluA[15:1]};
                statusD[`DSPC_ST_C]  = aluA[0];
                statusD[`DSPC_ST_OV] = 1'b0;
            end
            DSPC_K_ASRN: res = $signed(aluA) >>> shAmt;
            DSPC_K_NONE: res = 16'h0000;
        endcase
        if (aluKind != DSPC_K_NONE)
        begin
            statusD[`DSPC_ST_N] = res[15];
            statusD[`DSPC_ST_Z] = (res == 16'h0000);
            if (dstFile)
            begin
                memWe    = 1'b1;
                memWAddr = {3'b000, instrWord[`DSPC_F_FADDR]};
                memWData = res;
            end
            else if (dstMode == DSPC_AM_DIRECT)
                wD[dstReg] = res;
            else
            begin
                memWe        = 1'b1;
                memWAddr     = effAddr(dstMode, wQ[dstReg], 16'h0000);
                memWData     = res;
                wD[dstReg]   = ptrNext(dstMode, wQ[dstReg]);
            end
        end

        // Accumulator add touches only the accumulator flags
        accSum = {accQ[accSel][39], accQ[accSel]} + {accAddend[39], accAddend};
        if (accEn)
        begin
            accD[accSel] = accSum[39:0];
            statusD[accSel ? `DSPC_ST_OB : `DSPC_ST_OA] =
                !((&accSum[39:31]) || !(|accSum[39:31]));
            statusD[accSel ? `DSPC_ST_SB : `DSPC_ST_SA] = (accSum[40] != accSum[39]);
        end
    end

    // Working register file
    for (genvar i = 0; i < 16; i++)
    begin : gReg
        always_ff @(posedge clk)
        begin
            if (!rstn)
                wQ[i] <= 16'h0000;
            else if (busWr && (busWrIdx == `DSPC_IDX_W0 + 5'(i)) && (awaddr[31:7] == 25'h0))
            begin
                if (wstrb[0])
                    wQ[i][7:0] <= wdata[7:0];
                if (wstrb[1])
                    wQ[i][15:8] <= wdata[15:8];
            end
            else
                wQ[i] <= wD[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            accQ[0] <= 40'h0;
            accQ[1] <= 40'h0;
        end
        else
        begin
            accQ[0] <= accD[0];
            accQ[1] <= accD[1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            statusQ <= `DSPC_ST_RESET;
        else if (busWr && busWrMapped && (busWrIdx == `DSPC_IDX_STATUS))
        begin
            if (wstrb[0])
                statusQ[7:0] <= wdata[7:0];
            if (wstrb[1])
                statusQ[8] <= wdata[8];
        end
        else
            statusQ <= statusD;
    end

    // Write response
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            bvalidQ <= 1'b0;
            brespQ  <= `DSPC_RESP_OKAY;
        end
        else if (busWr)
        begin
            bvalidQ <= 1'b1;
            brespQ  <= busWrMapped ? `DSPC_RESP_OKAY : `DSPC_RESP_SLV;
        end
        else if (bready)
            bvalidQ <= 1'b0;
    end

    // Read data
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rvalidQ <= 1'b0;
            rrespQ  <= `DSPC_RESP_OKAY;
            rdataQ  <= 32'h0;
        end
        else if (arvalid && !rvalidQ)
        begin
            rvalidQ <= 1'b1;
            rrespQ  <= `DSPC_RESP_OKAY;
            rdataQ  <= 32'h0;
            if (araddr[31:7] != 25'h0)
                rrespQ <= `DSPC_RESP_SLV;
            else if (busRdIdx < `DSPC_IDX_STATUS)
                rdataQ <= {16'h0000, wQ[busRdIdx[3:0]]};
            else if (busRdIdx == `DSPC_IDX_STATUS)
                rdataQ <= {23'h0, statusQ};
            else if (busRdIdx == `DSPC_IDX_ACCALO)
                rdataQ <= accQ[0][31:0];
            else if (busRdIdx == `DSPC_IDX_ACCAHI)
                rdataQ <= {24'h0, accQ[0][39:32]};
            else if (busRdIdx == `DSPC_IDX_ACCBLO)
                rdataQ <= accQ[1][31:0];
            else if (busRdIdx == `DSPC_IDX_ACCBHI)
                rdataQ <= {24'h0, accQ[1][39:32]};
            else
                rrespQ <= `DSPC_RESP_SLV;
        end
        else if (rready)
            rvalidQ <= 1'b0;
    end

endmodule

// ===== sim/dspc_mem_model.sv
// Data memory model answering file register reads
`timescale 1ns/1ps
module dspc_mem_model (
    input wire logic        memRe,
    input wire logic [15:0] memRAddr,
    output logic     [15:0] memRData
);
    // Unselected, it shows the inverted address, never a held word
    assign memRData = memRe ? {memRAddr[7:0] ^ 8'h5a, memRAddr[7:0]} : ~memRAddr;
endmodule

// ===== sim/dspc_core_sva.sv
// Flag keeping and bus answer assertions of the core
`timescale 1ns/1ps
module dspc_core_sva
    import dspc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        awready,
    input wire logic        bvalid,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        instrValid,
    input wire logic [23:0] instrWord,
    input wire logic [8:0]  statusFlags
);
    wire logic [4:0] cls = instrWord[23:19];
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence op(logic [4:0] c);
        instrValid && cls == c;
    endsequence
    wr_resp_a: assert property (awready |=> bvalid) else $error("write unanswered");
    rd_resp_a: assert property (arvalid && arready |=> rvalid) else $error("read unanswered");
    wr_stall_a: assert property (awready |-> !instrValid && !bvalid) else $error("write taken");
    shift_keep_a: assert property ((op(DSPC_ASR_WL5) or op(DSPC_ASR_IMPLICIT_FILE_OP_REGISTER)) |=>
        (statusFlags & 9'h1f5) == ($past(statusFlags) & 9'h1f5)) else $error("C OV DC moved");
    shift_ov_a: assert property ((op(DSPC_ASR_WW) or op(DSPC_ASR_F)) |=>
        !statusFlags[2] && statusFlags[8:4] == $past(statusFlags[8:4])) else $error("OV kept");
    acc_keep_a: assert property ((op(DSPC_ADD_AB) or op(DSPC_ADD_WACC)) |=>
        $stable(statusFlags[4:0])) else $error("integer flags moved");
    add_keep_a: assert property (instrValid && cls >= DSPC_ADD_F && cls <= DSPC_ADD_WITH_CARRY_OP_WL5
        |=> $stable(statusFlags[8:5])) else $error("DSP flags moved");
    nop_keep_a: assert property (op(DSPC_NOP) |=> $stable(statusFlags))
        else $error("flags moved");
endmodule

bind dspc_core dspc_core_sva dspc_core_sva_i (.*);

// ===== sim/dsp_core_operand_and_alu_ops_tb_top.sv
// Random add, carry-add and shift runs checked over the register bus
`timescale 1ns/1ps
module dsp_core_operand_and_alu_ops_tb_top;
    logic clk = 1'b0, rstn = 1'b0, instrValid = 1'b0, bready = 1'b0, rready = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, memRe, memWe, xRe, yRe;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, seed = 32'h87cf;
    logic [23:0] instrWord = 24'h0;
    logic [15:0] memRAddr, memRData, memWAddr, memWData, xAddr, yAddr, a, b, e;
    logic [15:0] xRData = 16'h1234, yRData = 16'h0;
    logic [20:0] f;
    logic [14:0] ks;
    logic [8:0]  statusFlags;
    logic [4:0]  st;
    logic [3:0]  wstrb = 4'hf;
    logic [2:0]  awprot = 3'h0, arprot = 3'h0;
    logic [1:0]  bresp, rresp, rr;
    int          n_mismatch = 0, samples_checked = 0;
    dspc_core dspc_core_i (.*);
    dspc_mem_model dspc_mem_model_i (.*);
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Flags {DC, N, OV, Z, C} above the sum
    function automatic logic [20:0] addf(input logic [15:0] x, y, input logic c);
        logic [16:0] s;
        s = x + y + c;
        return {x[3:0] + y[3:0] + c > 5'h0f, s[15], x[15] == y[15] && s[15] != x[15],
                s[15:0] == 16'h0, s[16], s[15:0]};
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] ad, d);
        {awvalid, wvalid, awaddr, wdata, arvalid, araddr} <= {w, w, ad, d, !w, ad};
        do @(posedge clk); while (!(w ? awready : arready));
        {awvalid, wvalid, arvalid, bready, rready} <= {3'h0, w, !w};
        do @(posedge clk); while (!(w ? bvalid : rvalid));
        {bready, rready} <= 2'h0;
        {rr, rd} = w ? {bresp, 32'h0} : {rresp, rdata};
    endtask
    task automatic rdchk(input logic [31:0] ad, exp);
        bus(1'b0, ad, 32'h0);
        chk(rd, exp);
    endtask
    task automatic run(input logic [23:0] word);
        {instrValid, instrWord} <= {1'b1, word};
        @(posedge clk);
        instrValid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("%0d checks, %0d wrong", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #500000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            {a, b} = i == 0 ? 32'h7fff0001 : i == 1 ? 32'hffff0001 : rnd();
            ks = i == 0 ? 15'h7fff : 15'(rnd());
            bus(1'b1, 32'h0, {16'h0, a});
            bus(1'b1, 32'h4, {16'h0, a});
            bus(1'b1, 32'h8, {16'h0, b});
            run(24'h281230);
            f = addf(a, b, 1'b0);
            rdchk(32'hc, {16'h0, f[15:0]});
            run(24'h301230);
            f = addf(a, b, f[16]);
            rdchk(32'h40, {27'h0, f[20:16]});
            run({5'h04, 5'h0, ks[14:5], 4'h1});
            f = addf(a, {6'h0, ks[14:5]}, f[16]);
            rdchk(32'h4, {16'h0, f[15:0]});
            run(24'h600250);
            e = {b[15], b[15:1]};
            st = {f[20], e[15], 1'b0, e == 16'h0, b[0]};
            rdchk(32'h40, {27'h0, st});
            run({5'h0e, 3'h0, 4'h2, 4'h4, 3'h0, ks[4:0]});
            run(24'h0);
            run(24'h500000);
            e = 16'($signed(b) >>> ks[4:0]);
            st = {st[4], e[15], st[2], e == 16'h0, st[0]};
            rdchk(32'h10, {16'h0, e});
            rdchk(32'h40, {27'h0, st});
            run({5'h01, 5'h0, 1'b1, 5'h0, ks[14:7]});
            f = addf({ks[14:7] ^ 8'h5a, ks[14:7]}, a, 1'b0);
            rdchk(32'h0, {16'h0, f[15:0]});
            $display("test %0d end", i);
        end
        // Multiply W4*W5 into A with an X prefetch from [W8]+=2 into W6
        bus(1'b1, 32'h10, 32'h3);
        bus(1'b1, 32'h14, 32'h5);
        run(24'h800208);
        rdchk(32'h44, 32'hf);
        rdchk(32'h18, 32'h1234);
        rdchk(32'h20, 32'h2);
        rdchk(32'h80, 32'h0);
        chk({30'h0, rr}, 32'h2);
        give_verdict();
    end
endmodule
